/* File: hw/bsc_scan_ctrl.sv */
// Scan sequencing, operating mode and busy/alert control of the battery monitor.
`include "bsc_consts.svh"
module bsc_scan_ctrl
   import bsc_pkg::*;
#(
   parameter int unsigned DELAY_STEP_CYCLES = `BSC_DELAY_STEP_CYC,
   parameter int unsigned MEAS_CYCLES       = `BSC_MEAS_CYC,
   parameter int unsigned LP_BASE_SCANS     = `BSC_LP_BASE_SCANS
) (
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   // Register access port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   // Measurement front end
   input  wire logic       current_flow_in,
   output logic      [6:0] meas_select_out,
   output logic      [1:0] operating_mode_out,
   // Pin
   output logic            alert_output_out
);
   localparam int NM = `BSC_NUM_MEAS;

   logic [7:0]      cfg_q, cfg_d;
   logic [7:0]      men_q, men_d;
   logic [7:0]      amask_q, amask_d;
   logic            single_q, single_d;
   logic            cont_q, cont_d;
   bsc_scan_state_t sc_q, sc_d;
   logic [31:0]     dly_q, dly_d;
   logic [15:0]     quiet_q, quiet_d;
   logic            cur_seen_q, cur_seen_d;
   logic            start_q, start_d;
   logic [7:0]      rdata_q, rdata_d;
   logic            alert_q, alert_d;

   logic            seq_busy;
   logic            seq_done;
   logic [NM-1:0]   meas_en;
   bsc_mode_t       mode;
   logic            gop_wr, trig_ok, run_mode;
   logic [15:0]     lp_limit;
   logic [31:0]     dly_limit;

   assign mode     = bsc_mode_t'(cfg_q[`BSC_CFG_MODE_HI:`BSC_CFG_MODE_LO]);
   assign run_mode = (mode == BSC_MODE_SCAN) || (mode == BSC_MODE_LOW_POWER);
   assign gop_wr   = reg_wr_in && (reg_addr_in == `BSC_ADDR_GLOBAL_OPS);
   // Triggers are honoured only in scan mode with nothing running.
   assign trig_ok  = gop_wr && reg_wdata_in[`BSC_GOP_TRIG_BIT] && (mode == BSC_MODE_SCAN) && (sc_q == BSC_SC_IDLE);
   assign lp_limit = 16'(LP_BASE_SCANS) << cfg_q[`BSC_CFG_LPT_HI:`BSC_CFG_LPT_LO];
   assign dly_limit = (32'(cfg_q[`BSC_CFG_DLY_HI:`BSC_CFG_DLY_LO]) + 32'd1) * DELAY_STEP_CYCLES;
   // Enable order: cell, pack current, pack voltage, die temp, open wire, aux 1st, aux 2nd.
   assign meas_en  = men_q[NM-1:0];

   bsc_meas_seq #(
      .MEAS_CYCLES (MEAS_CYCLES),
      .NUM_MEAS    (NM)
   ) u_seq (
      .sys_clk_in      (sys_clk_in),
      .srst_in         (srst_in),
      .start_in        (start_q),
      .enable_in       (meas_en),
      .busy_out        (seq_busy),
      .done_out        (seq_done),
      .meas_select_out (meas_select_out)
   );

   always_comb begin
      cfg_d      = cfg_q;
      men_d      = men_q;
      amask_d    = amask_q;
      single_d   = single_q;
      cont_d     = cont_q;
      sc_d       = sc_q;
      dly_d      = dly_q;
      quiet_d    = quiet_q;
      cur_seen_d = cur_seen_q || current_flow_in;
      start_d    = 1'b0;
      rdata_d    = rdata_q;

      if (reg_wr_in) begin
         case (reg_addr_in)
            `BSC_ADDR_SCAN_CFG: begin
               cfg_d = reg_wdata_in;
            end
            `BSC_ADDR_MEAS_EN: begin
               men_d = {1'b0, reg_wdata_in[6:0]};
            end
            `BSC_ADDR_ALERT_MASK: begin
               amask_d = reg_wdata_in;
            end
            default: begin
            end
         endcase
      end

      // The busy position is not writable; only single select is stored, and the trigger bit reads back as 0.
      if (gop_wr) begin
         single_d = reg_wdata_in[`BSC_GOP_SINGLE_BIT];
         if (!reg_wdata_in[`BSC_GOP_TRIG_BIT]) begin
            cont_d = 1'b0;
         end
      end

      case (sc_q)
         BSC_SC_IDLE: begin
            if (trig_ok) begin
               cont_d     = !reg_wdata_in[`BSC_GOP_SINGLE_BIT];
               start_d    = 1'b1;
               cur_seen_d = 1'b0;
               sc_d       = BSC_SC_RUN;
            end
         end
         BSC_SC_RUN: begin
            if (seq_done) begin
               cur_seen_d = 1'b0;
               if (mode == BSC_MODE_SCAN) begin
                  if (cur_seen_q) begin
                     quiet_d = '0;
                  end else if (quiet_q + 16'd1 >= lp_limit) begin
                     quiet_d = '0;
                     cfg_d[`BSC_CFG_MODE_HI:`BSC_CFG_MODE_LO] = BSC_MODE_LOW_POWER;
                  end else begin
                     quiet_d = quiet_q + 16'd1;
                  end
               end
               // Only continuous scanning waits out the delay.
               dly_d = '0;
               sc_d  = (cont_d && run_mode) ? BSC_SC_WAIT : BSC_SC_IDLE;
            end
         end
         BSC_SC_WAIT: begin
            if (!cont_q || !run_mode) begin
               sc_d = BSC_SC_IDLE;
            end else if (dly_q >= dly_limit - 32'd1) begin
               start_d    = 1'b1;
               cur_seen_d = 1'b0;
               sc_d       = BSC_SC_RUN;
            end else begin
               dly_d = dly_q + 32'd1;
            end
         end
         default: begin
            sc_d = BSC_SC_IDLE;
         end
      endcase

      if (reg_rd_in) begin
         case (reg_addr_in)
            `BSC_ADDR_GLOBAL_OPS: rdata_d = {5'h00, seq_busy, single_q, 1'b0};
            `BSC_ADDR_SCAN_CFG:   rdata_d = cfg_q;
            `BSC_ADDR_MEAS_EN:    rdata_d = men_q;
            `BSC_ADDR_ALERT_MASK: rdata_d = amask_q;
            default:              rdata_d = 8'h00;
         endcase
      end

      // Alert lags busy by one clock so that the pin comes straight off a flop.
      alert_d = amask_q[`BSC_MASK_BUSY_BIT] ? 1'b1 : !seq_busy;
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         cfg_q      <= `BSC_SCAN_CFG_RESET;
         men_q      <= `BSC_MEAS_EN_RESET;
         amask_q    <= `BSC_ALERT_MASK_RESET;
         single_q   <= 1'b0;
         cont_q     <= 1'b0;
         sc_q       <= BSC_SC_IDLE;
         dly_q      <= '0;
         quiet_q    <= '0;
         cur_seen_q <= 1'b0;
         start_q    <= 1'b0;
         rdata_q    <= 8'h00;
         alert_q    <= 1'b1;
      end else begin
         cfg_q      <= cfg_d;
         men_q      <= men_d;
         amask_q    <= amask_d;
         single_q   <= single_d;
         cont_q     <= cont_d;
         sc_q       <= sc_d;
         dly_q      <= dly_d;
         quiet_q    <= quiet_d;
         cur_seen_q <= cur_seen_d;
         start_q    <= start_d;
         rdata_q    <= rdata_d;
         alert_q    <= alert_d;
      end
   end

   assign reg_rdata_out      = rdata_q;
   assign operating_mode_out = cfg_q[`BSC_CFG_MODE_HI:`BSC_CFG_MODE_LO];
   assign alert_output_out   = alert_q;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);

   sequence s_trigger_write;
      trig_ok;
   endsequence

   sequence s_pass_begins;
      start_q ##1 seq_busy;
   endsequence

   a_mode_reset_idle: assert property (disable iff (1'b0) srst_in |=> (mode == BSC_MODE_IDLE && !start_q))
      else $error("reset did not leave idle mode");

   a_cfg_write_held: assert property ((reg_wr_in && reg_addr_in == `BSC_ADDR_SCAN_CFG && sc_q == BSC_SC_IDLE)
      |=> cfg_q == $past(reg_wdata_in))
      else $error("scan config write not stored");

   a_trigger_starts: assert property (s_trigger_write |=> s_pass_begins)
      else $error("trigger did not start a pass");

   a_idle_no_scan: assert property ((mode == BSC_MODE_IDLE && sc_q == BSC_SC_IDLE) |=> !start_q)
      else $error("scan started in idle mode");

   a_single_one_pass: assert property ((seq_done && !cont_q && !gop_wr) |=> (sc_q == BSC_SC_IDLE) [*2])
      else $error("single scan did not stop after one pass");

   a_cont_waits: assert property ((seq_done && cont_q && !gop_wr && mode == BSC_MODE_SCAN)
      |=> sc_q == BSC_SC_WAIT ##1 !start_q)
      else $error("continuous scan did not enter delay");

   a_stop_write: assert property ((gop_wr && reg_wdata_in == `BSC_GOP_STOP_VALUE) |=> !cont_q)
      else $error("stop write did not end continuous scanning");

   a_busy_read: assert property ((reg_rd_in && reg_addr_in == `BSC_ADDR_GLOBAL_OPS)
      |=> reg_rdata_out[`BSC_GOP_BUSY_BIT] == $past(seq_busy))
      else $error("busy bit read back wrong");

   a_alert_busy: assert property ((!amask_q[`BSC_MASK_BUSY_BIT] && !$changed(amask_q))
      |-> alert_output_out == !$past(seq_busy))
      else $error("alert does not follow inverted busy");

   a_lp_entry: assert property ((seq_done && sc_q == BSC_SC_RUN && mode == BSC_MODE_SCAN && !cur_seen_q
      && quiet_q + 16'd1 >= lp_limit && !reg_wr_in) |=> mode == BSC_MODE_LOW_POWER)
      else $error("low power entry missed");
endmodule

/* File: hw/bsc_consts.svh */
// Register offsets, field positions, reset values and timing counts of the scan controller.
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

`define BSC_ADDR_GLOBAL_OPS  8'h01
`define BSC_ADDR_SCAN_CFG    8'h2e
`define BSC_ADDR_ALERT_MASK  8'h65
`define BSC_ADDR_MEAS_EN     8'h1a

`define BSC_GOP_TRIG_BIT     0
`define BSC_GOP_SINGLE_BIT   1
`define BSC_GOP_BUSY_BIT     2
`define BSC_GOP_STOP_VALUE   8'h02

`define BSC_CFG_MODE_HI      7
`define BSC_CFG_MODE_LO      6
`define BSC_CFG_LPT_HI       5
`define BSC_CFG_LPT_LO       3
`define BSC_CFG_DLY_HI       2
`define BSC_CFG_DLY_LO       0
`define BSC_MASK_BUSY_BIT    0

`define BSC_SCAN_CFG_RESET   8'h1b
`define BSC_MEAS_EN_RESET    8'h7f
`define BSC_ALERT_MASK_RESET 8'h01

`define BSC_CLK_HZ           20000000
`define BSC_DELAY_STEP_MS    32
`define BSC_DELAY_STEP_CYC   (`BSC_DELAY_STEP_MS * (`BSC_CLK_HZ / 1000))
`define BSC_MEAS_TIME_US     100
`define BSC_MEAS_CYC         ((`BSC_MEAS_TIME_US * (`BSC_CLK_HZ / 1000)) / 1000)
`define BSC_LP_BASE_SCANS    16
`define BSC_NUM_MEAS         7

`endif

/* File: hw/bsc_pkg.sv */
// Types shared by the battery monitor scan controller.
package bsc_pkg;
   typedef enum logic [1:0] {
      BSC_MODE_IDLE,
      BSC_MODE_SCAN,
      BSC_MODE_LOW_POWER,
      BSC_MODE_SHIP
   } bsc_mode_t;

   typedef enum logic [1:0] {
      BSC_SC_IDLE,
      BSC_SC_RUN,
      BSC_SC_WAIT
   } bsc_scan_state_t;
endpackage

/* File: hw/bsc_meas_seq.sv */
// Measurement pass sequencer: runs each enabled measurement slot in turn.
`include "bsc_consts.svh"
module bsc_meas_seq
   import bsc_pkg::*;
#(
   parameter int unsigned MEAS_CYCLES = `BSC_MEAS_CYC,
   parameter int unsigned NUM_MEAS    = `BSC_NUM_MEAS
) (
   // Clock and reset
   input  wire logic                sys_clk_in,
   input  wire logic                srst_in,
   // Pass control
   input  wire logic                start_in,
   input  wire logic [NUM_MEAS-1:0] enable_in,
   output logic                     busy_out,
   output logic                     done_out,
   output logic [NUM_MEAS-1:0]      meas_select_out
);
   localparam int IW = $clog2(NUM_MEAS);

   logic [NUM_MEAS-1:0] mask_q, mask_d;
   logic [IW-1:0]       idx_q, idx_d;
   logic [31:0]         cnt_q, cnt_d;
   logic                busy_q, busy_d;
   logic                done_q, done_d;
   logic [NUM_MEAS-1:0] sel_q, sel_d;

   // Lowest enabled slot at or above 'from'; bit IW flags that one exists.
   function automatic logic [IW:0] next_en(input logic [NUM_MEAS-1:0] m, input int from);
      logic [IW:0] r;
      r = '0;
      for (int i = NUM_MEAS - 1; i >= 0; i--) begin
         if (i >= from && m[i]) begin
            r = {1'b1, IW'(i)};
         end
      end
      return r;
   endfunction

   always_comb begin
      logic [IW:0] nx;
      nx     = '0;
      mask_d = mask_q;
      idx_d  = idx_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (!busy_q) begin
         if (start_in) begin
            // The pass covers the enables as they stood at the trigger.
            nx     = next_en(enable_in, 0);
            mask_d = enable_in;
            idx_d  = nx[IW-1:0];
            cnt_d  = '0;
            busy_d = 1'b1;
         end
      end else if (!mask_q[idx_q] || cnt_q == MEAS_CYCLES - 1) begin
         nx = next_en(mask_q, int'(idx_q) + 1);
         if (nx[IW]) begin
            idx_d = nx[IW-1:0];
            cnt_d = '0;
         end else begin
            // Busy clears only once the last enabled slot has finished.
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end else begin
         cnt_d = cnt_q + 32'd1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_MEAS; g++) begin : g_sel
         assign sel_d[g] = busy_d && mask_d[g] && (idx_d == IW'(g));
      end
   endgenerate

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         mask_q <= '0;
         idx_q  <= '0;
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         sel_q  <= '0;
      end else begin
         mask_q <= mask_d;
         idx_q  <= idx_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
         sel_q  <= sel_d;
      end
   end

   assign busy_out        = busy_q;
   assign done_out        = done_q;
   assign meas_select_out = sel_q;

   a_skip_disabled: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (sel_q != '0) |-> ((sel_q & ~mask_q) == '0))
      else $error("disabled measurement slot selected");

   a_done_ends_busy: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      done_q |-> (!busy_q && $past(busy_q)))
      else $error("pass done without busy falling");
endmodule

/* File: dv/bsc_host_model.sv */
// Host controller model that reaches the scan controller through its register port.
module bsc_host_model (
   // Clock
   input  wire logic       sys_clk_in,
   // Register access port
   output logic      [7:0] reg_addr_out,
   output logic      [7:0] reg_wdata_out,
   output logic            reg_wr_out,
   output logic            reg_rd_out
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      reg_addr_out  = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out    = 1'b0;
      reg_rd_out    = 1'b0;
   end

   // Address and data are inverted once a strobe ends, so a stale value is never mistaken for a live one.
   task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic is_wr);
      @(negedge sys_clk_in);
      reg_addr_out  <= addr;
      reg_wdata_out <= data;
      reg_wr_out    <= is_wr;
      reg_rd_out    <= ~is_wr;
      @(negedge sys_clk_in);
      reg_addr_out  <= ~addr;
      reg_wdata_out <= ~data;
      reg_wr_out    <= 1'b0;
      reg_rd_out    <= 1'b0;
   endtask

   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      access(addr, data, 1'b1);
   endtask

   task automatic read(input logic [7:0] addr);
      access(addr, 8'h00, 1'b0);
   endtask

   task automatic trigger(input logic single);
      write(8'h01, {6'h00, single, 1'b1});
   endtask

   task automatic stop_scan();
      write(8'h01, 8'h02);
   endtask

   // Settings are changed only with scanning stopped, hence the stop in front of every change.
   task automatic configure(input logic [7:0] addr, input logic [7:0] data);
      stop_scan();
      write(addr, data);
   endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking testbench of the battery monitor scan controller.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned STEP = 4;
   localparam int unsigned MEAS = 3;
   logic       sys_clk_in;
   logic       srst_in;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       reg_wr;
   logic       reg_rd;
   logic       current_flow;
   logic       alert;
   logic [6:0] meas_select;
   logic [1:0] mode;
   logic       rd_seen;
   logic [7:0] exp_q[$];
   int         n_errors;
   int         cmp_count;

   initial sys_clk_in = 1'b0;
   always #25 sys_clk_in = ~sys_clk_in;

   bsc_host_model bsc_host_model_inst (
      .sys_clk_in(sys_clk_in), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
      .reg_wr_out(reg_wr), .reg_rd_out(reg_rd)
   );

   bsc_scan_ctrl #(.DELAY_STEP_CYCLES(STEP), .MEAS_CYCLES(MEAS), .LP_BASE_SCANS(1)) bsc_scan_ctrl_inst (
      .sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .current_flow_in(current_flow),
      .meas_select_out(meas_select), .operating_mode_out(mode), .alert_output_out(alert)
   );

   task automatic report_and_stop();
      if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask

   task automatic timeout();
      n_errors++;
      report_and_stop();
   endtask

   // Read data is judged by the monitor below, one cycle after the strobe.
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      exp_q.push_back(exp);
      bsc_host_model_inst.read(addr);
   endtask

   always @(posedge sys_clk_in) rd_seen <= reg_rd;

   always @(negedge sys_clk_in) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) timeout();
         else cmp8(reg_rdata, exp_q.pop_front());
      end
   end

   // Waits for the next busy period on the alert pin and measures it.
   task automatic watch_pass(output int gap, output int lows, output logic [6:0] seen);
      gap = 0;
      lows = 0;
      seen = 7'h00;
      while (alert !== 1'b0) begin
         @(negedge sys_clk_in);
         gap++;
         if (gap > 400) timeout();
      end
      while (alert === 1'b0) begin
         seen |= meas_select;
         @(negedge sys_clk_in);
         lows++;
         if (lows > 400) timeout();
      end
   endtask

   task automatic expect_quiet(input int n);
      logic act;
      act = 1'b0;
      repeat (n) begin
         @(negedge sys_clk_in);
         act |= (alert !== 1'b1) || (meas_select !== 7'h00);
      end
      cmp8({7'h00, act}, 8'h00);
   endtask

   initial begin
      int gap;
      int lows;
      int d;
      logic [6:0] seen;
      logic [7:0] v;
      srst_in = 1'b1;
      current_flow = 1'b1;
      n_errors = 0;
      cmp_count = 0;
      void'($urandom(95));
      repeat (2) @(negedge sys_clk_in);
      srst_in = 1'b0;
      cmp8({6'h00, mode}, 8'h00);
      rd_chk(8'h2e, 8'h1b);
      rd_chk(8'h1a, 8'h7f);
      rd_chk(8'h01, 8'h00);
      rd_chk(8'h77, 8'h00);
      bsc_host_model_inst.write(8'h65, 8'h00);
      rd_chk(8'h65, 8'h00);
      bsc_host_model_inst.write(8'h01, 8'h06);
      rd_chk(8'h01, 8'h02);
      bsc_host_model_inst.trigger(1'b1);
      expect_quiet(30);
      for (int m = 0; m < 4; m++) begin
         v = {m[1:0], 6'($urandom())};
         bsc_host_model_inst.configure(8'h2e, v);
         rd_chk(8'h2e, v);
         cmp8({6'h00, mode}, {6'h00, m[1:0]});
      end
      bsc_host_model_inst.configure(8'h2e, 8'h7f);
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 8'h00 : {1'b0, k[1:0], 5'($urandom())};
         bsc_host_model_inst.configure(8'h1a, v);
         // Random current is harmless here, since these few passes stay far below the low-power count.
         current_flow = 1'($urandom());
         bsc_host_model_inst.trigger(1'b1);
         watch_pass(gap, lows, seen);
         cmp8({1'b0, seen}, v);
         cmp8(8'(lows), (v == 8'h00) ? 8'h01 : 8'($countones(v) * MEAS));
         expect_quiet(40);
      end
      bsc_host_model_inst.configure(8'h1a, 8'h7f);
      bsc_host_model_inst.trigger(1'b1);
      @(negedge sys_clk_in);
      rd_chk(8'h01, 8'h06);
      watch_pass(gap, lows, seen);
      rd_chk(8'h01, 8'h02);
      cmp8({7'h00, alert}, 8'h01);
      bsc_host_model_inst.configure(8'h1a, 8'h01);
      for (int i = 0; i < 2; i++) begin
         d = (i == 0) ? 0 : 1 + ($urandom() % 7);
         bsc_host_model_inst.configure(8'h2e, {5'b01111, d[2:0]});
         bsc_host_model_inst.trigger(1'b0);
         watch_pass(gap, lows, seen);
         watch_pass(gap, lows, seen);
         cmp8({7'h00, gap >= (d + 1) * STEP && gap <= (d + 1) * STEP + 4}, 8'h01);
         bsc_host_model_inst.stop_scan();
         expect_quiet(60);
      end
      current_flow = 1'b1;
      bsc_host_model_inst.configure(8'h2e, 8'h48);
      bsc_host_model_inst.trigger(1'b0);
      watch_pass(gap, lows, seen);
      current_flow = 1'b0;
      watch_pass(gap, lows, seen);
      repeat (2) @(negedge sys_clk_in);
      cmp8({6'h00, mode}, 8'h01);
      watch_pass(gap, lows, seen);
      repeat (2) @(negedge sys_clk_in);
      cmp8({6'h00, mode}, 8'h02);
      watch_pass(gap, lows, seen);
      bsc_host_model_inst.stop_scan();
      rd_chk(8'h2e, 8'h88);
      expect_quiet(40);
      report_and_stop();
   end
endmodule
